// ### rtl/lite_timer_regs.svh
// Offsets, field positions, reset values and counts of the lite timer
`ifndef LITE_TIMER_REGS_SVH
`define LITE_TIMER_REGS_SVH

// Register indices; byte address is four times the index
`define LT_IDX_CTRL_STATUS   8'h0B
`define LT_IDX_CAPTURE       8'h0C
`define LT_ADDR_CTRL_STATUS  12'h02C
`define LT_ADDR_CAPTURE      12'h030

// Control/status field positions
`define LT_BIT_CAP_IRQ_EN    7
`define LT_BIT_CAP_FLAG      6
`define LT_BIT_PERIOD_DBL    5
`define LT_BIT_TICK_IRQ_EN   4
`define LT_BIT_TICK_FLAG     3
`define LT_BIT_DOG_FORCE     2
`define LT_BIT_DOG_ENABLE    1
`define LT_BIT_DOG_DELAY     0

// Reset values
`define LT_CTRL_RESET        8'h00
`define LT_CAPTURE_RESET     8'h00

// Counter terminal value and capture slice
`define LT_CNT_TERMINAL      13'h1F39
`define LT_CAP_MSB           12
`define LT_CAP_LSB           5

// Watchdog resume delays after wake from halt, in clocks
`define LT_RESUME_SHORT      10'h100
`define LT_RESUME_LONG       10'h200

`endif

// ### rtl/lite_timer_pkg.sv
// Types shared by the lite timer block
package lite_timer_pkg;

  typedef struct packed {
    logic cap_irq_en;
    logic capture_flag;
    logic period_double_sel;
    logic tick_irq_en;
    logic tick_flag;
    logic dog_force_status;
    logic dog_enable;
    logic dog_delay;
  } timer_ctrl_status_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// ### rtl/lite_timebase_watchdog_capture.sv
// Lite timer: timebase, watchdog and input capture with an APB slave
//
// Behaviour
// - Hidden 13-bit counter, zero after reset, counts
// - Overflow event on wrap from terminal value
// - Period select doubles the tick interval
// - Overflow sets tick flag, enabled raises request
// - Status read clears tick flag, writes ignored
// - Enabled watchdog resets after two counter wraps unrefreshed
// - Delay bit cleared at each watchdog period end
// - Period counted from reset; late enable resets
// - Writing force bit while active forces reset
// - Force bit flags watchdog reset, cleared on read
// - Status set when watchdog activates resets at once
// - Hardware option keeps watchdog always active
// - Halt without reset option stops counter and watchdog
// - After wake, resume after 256/512 clocks
// - Pin edge captures counter byte, sets flag
// - Set capture flag blocks captures; read clears
// - Wait and active-halt leave the timer running
// - Two gated requests with wake-up routing
// - Periods of one and two counter wraps
// - Status flag cleared by read or supply reset
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "lite_timer_regs.svh"

module lite_timebase_watchdog_capture (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     lvd_rst_n,
  input  wire lite_timer_pkg::apb_req_t apb_req,
  output      lite_timer_pkg::apb_rsp_t apb_rsp,
  input  wire logic                     capture_pin,
  input  wire logic                     hw_dog_opt,
  input  wire logic                     halt_reset_opt,
  input  wire logic                     resume_long_sel,
  input  wire logic                     halt_mode,
  input  wire logic                     wait_mode,
  input  wire logic                     active_halt_mode,
  input  wire logic                     cpu_irq_mask,
  output      logic                     tick_irq,
  output      logic                     capture_irq,
  output      logic                     tick_wake,
  output      logic                     capture_wake,
  output      logic                     dog_reset
);

  typedef enum logic [1:0] {RUN, HALTED, RESUMING} run_state_t;

  run_state_t  run_q;
  run_state_t  run_d;
  logic [12:0] cnt_q;
  logic        wrap_half_q;
  logic        dog_half_q;
  logic [9:0]  resume_q;
  logic [9:0]  resume_d;
  logic        cap_irq_en_q;
  logic        period_sel_q;
  logic        tick_irq_en_q;
  logic        tick_flag_q;
  logic        capture_flag_q;
  logic        dog_enable_q;
  logic        dog_delay_q;
  logic        dog_status_q;
  logic        expired_q;
  logic        active_q;
  logic [7:0]  capture_q;
  logic [2:0]  pin_sync_q;
  logic [1:0]  opt_sync_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        tick_irq_q;
  logic        capture_irq_q;
  logic        tick_wake_q;
  logic        capture_wake_q;
  logic        dog_reset_q;

  // Reset image of the control bits, so each reset branch assigns a constant
  localparam logic [7:0] CTRL_RST = `LT_CTRL_RESET;

  function automatic logic hits(input logic [11:0] addr, input logic [11:0] target);
    hits = (addr == target);
  endfunction

  // Bus decode; no wait state, read data registered in the setup cycle comes from a flip-flop
  wire setup_phase  = apb_req.psel & ~apb_req.penable;
  wire access_done  = apb_req.psel & apb_req.penable & pready_q;
  wire sel_ctrl     = hits(apb_req.paddr, `LT_ADDR_CTRL_STATUS);
  wire sel_cap      = hits(apb_req.paddr, `LT_ADDR_CAPTURE);
  wire unmapped     = ~sel_ctrl & ~sel_cap;
  wire wr_ctrl      = access_done & apb_req.pwrite & sel_ctrl;
  wire rd_ctrl      = access_done & ~apb_req.pwrite & sel_ctrl;
  wire rd_cap       = access_done & ~apb_req.pwrite & sel_cap;
  wire [7:0] wbyte  = apb_req.pwdata[7:0];

  lite_timer_pkg::timer_ctrl_status_t csr_view;
  assign csr_view = '{cap_irq_en:        cap_irq_en_q,
                      capture_flag:      capture_flag_q,
                      period_double_sel: period_sel_q,
                      tick_irq_en:       tick_irq_en_q,
                      tick_flag:         tick_flag_q,
                      dog_force_status:  dog_status_q,
                      dog_enable:        dog_enable_q,
                      dog_delay:         dog_delay_q};

  wire [31:0] rdata_mux = sel_ctrl ? {24'h000000, csr_view} :
                          sel_cap  ? {24'h000000, capture_q} : 32'h00000000;

  // Halt handling: counter frozen while halted or resuming
  wire halt_stops   = halt_mode & ~halt_reset_opt;
  wire counting     = (run_q == RUN);
  wire [9:0] resume_len = resume_long_sel ? `LT_RESUME_LONG : `LT_RESUME_SHORT;

  always_comb begin
    run_d    = run_q;
    resume_d = resume_q;
    case (run_q)
      RUN: begin
        if (halt_stops) begin
          run_d = HALTED;
        end
      end
      HALTED: begin
        if (!halt_mode) begin
          run_d    = RESUMING;
          resume_d = resume_len - 10'h001;
        end
      end
      RESUMING: begin
        if (resume_q == 10'h000) begin
          run_d = RUN;
        end else begin
          resume_d = resume_q - 10'h001;
        end
      end
      default: begin
        run_d = RUN;
      end
    endcase
  end

  wire wrap      = counting & (cnt_q == `LT_CNT_TERMINAL);
  wire [12:0] cnt_d = wrap ? 13'h0000 : (counting ? cnt_q + 13'h0001 : cnt_q);
  // doubled period uses every second wrap
  wire tick_evt  = wrap & (~period_sel_q | wrap_half_q);
  wire dog_end   = wrap & dog_half_q;

  // capture pin synchronised, edge from second and third stage
  wire pin_edge  = pin_sync_q[1] ^ pin_sync_q[2];
  // capture only while flag is clear
  wire cap_evt   = pin_edge & ~capture_flag_q;

  // hardware option makes watchdog permanently active
  wire active_d  = opt_sync_q[1] | dog_enable_q;
  wire delay_set = wr_ctrl & wbyte[`LT_BIT_DOG_DELAY];

  // unrefreshed period end, or late enable after expiry
  wire reset_timeout = active_q & ((dog_end & ~dog_delay_q) | (expired_q & ~dog_delay_q));
  wire reset_force   = active_q & wr_ctrl & wbyte[`LT_BIT_DOG_FORCE];
  // stale status on activation resets at once
  wire reset_stale   = active_d & ~active_q & dog_status_q;
  wire reset_halt    = active_q & halt_mode & halt_reset_opt;
  wire dog_fire      = reset_timeout | reset_force | reset_stale | reset_halt;

  // Timebase and watchdog counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q       <= RUN;
      resume_q    <= 10'h000;
      cnt_q       <= 13'h0000;
      wrap_half_q <= 1'b0;
      dog_half_q  <= 1'b0;
    end else begin
      run_q       <= run_d;
      resume_q    <= resume_d;
      cnt_q       <= cnt_d;
      wrap_half_q <= wrap ? ~wrap_half_q : wrap_half_q;
      dog_half_q  <= wrap ? ~dog_half_q : dog_half_q;
    end
  end

  // Synchronisers for pin and option strap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= 3'h0;
      opt_sync_q <= 2'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], capture_pin};
      opt_sync_q <= {opt_sync_q[0], hw_dog_opt};
    end
  end

  // Software control bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_irq_en_q  <= CTRL_RST[`LT_BIT_CAP_IRQ_EN];
      period_sel_q  <= CTRL_RST[`LT_BIT_PERIOD_DBL];
      tick_irq_en_q <= CTRL_RST[`LT_BIT_TICK_IRQ_EN];
      dog_enable_q  <= CTRL_RST[`LT_BIT_DOG_ENABLE];
    end else if (wr_ctrl) begin
      cap_irq_en_q  <= wbyte[`LT_BIT_CAP_IRQ_EN];
      period_sel_q  <= wbyte[`LT_BIT_PERIOD_DBL];
      tick_irq_en_q <= wbyte[`LT_BIT_TICK_IRQ_EN];
      dog_enable_q  <= wbyte[`LT_BIT_DOG_ENABLE];
    end
  end

  // Flags: an overflow in the tick flag's clearing cycle wins; a pin edge while the capture flag is set is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_flag_q    <= 1'b0;
      capture_flag_q <= 1'b0;
      capture_q      <= `LT_CAPTURE_RESET;
    end else begin
      // tick flag set by overflow, cleared by status read
      tick_flag_q    <= tick_evt | (tick_flag_q & ~rd_ctrl);
      capture_flag_q <= cap_evt | (capture_flag_q & ~rd_cap);
      if (cap_evt) begin
        capture_q <= cnt_q[`LT_CAP_MSB:`LT_CAP_LSB];
      end
    end
  end

  // Watchdog state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dog_delay_q <= CTRL_RST[`LT_BIT_DOG_DELAY];
      expired_q   <= 1'b0;
      active_q    <= 1'b0;
      dog_reset_q <= 1'b0;
    end else begin
      // refresh sets delay, period end clears it
      dog_delay_q <= delay_set | (dog_delay_q & ~dog_end);
      // expiry remembered from reset until a refresh
      expired_q   <= ~delay_set & (expired_q | (dog_end & ~dog_delay_q));
      active_q    <= active_d;
      dog_reset_q <= dog_fire;
    end
  end

  // status survives system reset; supply reset or a status read clears it
  always_ff @(posedge clk or negedge lvd_rst_n) begin
    if (!lvd_rst_n) begin
      dog_status_q <= 1'b0;
    end else begin
      // set by watchdog reset, cleared by status read only
      // A write must not clear it, or enabling would hide a stale flag
      if (dog_fire) begin
        dog_status_q <= 1'b1;
      end else if (rd_ctrl) begin
        dog_status_q <= 1'b0;
      end
    end
  end

  // Bus response registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase & unmapped;
      prdata_q  <= (setup_phase & ~apb_req.pwrite) ? rdata_mux : 32'h00000000;
    end
  end

  // gated requests; tick wakes wait and active-halt, capture wait only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_irq_q     <= 1'b0;
      capture_irq_q  <= 1'b0;
      tick_wake_q    <= 1'b0;
      capture_wake_q <= 1'b0;
    end else begin
      tick_irq_q     <= tick_flag_q & tick_irq_en_q & ~cpu_irq_mask;
      capture_irq_q  <= capture_flag_q & cap_irq_en_q & ~cpu_irq_mask;
      tick_wake_q    <= tick_flag_q & tick_irq_en_q & (wait_mode | active_halt_mode);
      capture_wake_q <= capture_flag_q & cap_irq_en_q & wait_mode;
    end
  end

  assign apb_rsp.pready  = pready_q;
  assign apb_rsp.pslverr = pslverr_q;
  assign apb_rsp.prdata  = prdata_q;
  assign tick_irq        = tick_irq_q;
  assign capture_irq     = capture_irq_q;
  assign tick_wake       = tick_wake_q;
  assign capture_wake    = capture_wake_q;
  assign dog_reset       = dog_reset_q;

endmodule

// ### verif/lite_timer_properties.sv
// Port-level checks for the lite timer
`timescale 1ns/100ps
module lite_timer_properties (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire lite_timer_pkg::apb_req_t apb_req,
  input wire lite_timer_pkg::apb_rsp_t apb_rsp,
  input wire logic                     halt_mode,
  input wire logic                     halt_reset_opt,
  input wire logic                     wait_mode,
  input wire logic                     active_halt_mode,
  input wire logic                     cpu_irq_mask,
  input wire logic                     tick_irq,
  input wire logic                     capture_irq,
  input wire logic                     tick_wake,
  input wire logic                     capture_wake,
  input wire logic                     dog_reset
);
  logic [15:0] cyc_q;
  // Saturates so a long run never wraps the bound
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cyc_q <= 16'h0000;
    else if (cyc_q != 16'hFFFF)
      cyc_q <= cyc_q + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  setup_ready_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready after setup");
  ready_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  error_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("error without ready");
  tick_mask_a: assert property (tick_irq |-> !$past(cpu_irq_mask))
    else $error("tick request while masked");
  cap_mask_a: assert property (capture_irq |-> !$past(cpu_irq_mask))
    else $error("capture request while masked");
  tick_wake_a: assert property (tick_wake |-> $past(wait_mode || active_halt_mode))
    else $error("tick wake outside wait");
  cap_wake_a: assert property (capture_wake |-> $past(wait_mode))
    else $error("capture wake outside wait");
  halt_quiet_a: assert property (
    halt_mode && $past(halt_mode) && $past(halt_mode, 2) && !halt_reset_opt |-> !dog_reset)
    else $error("watchdog fired in halt");
  first_tick_a: assert property ($rose(tick_irq) |-> cyc_q > 16'h1F36)
    else $error("tick before first wrap");
  cover property ($rose(tick_irq));
  cover property ($rose(capture_irq));
  cover property (dog_reset);
endmodule

bind lite_timebase_watchdog_capture lite_timer_properties u_props (
  .clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .halt_mode(halt_mode),
  .halt_reset_opt(halt_reset_opt), .wait_mode(wait_mode), .active_halt_mode(active_halt_mode),
  .cpu_irq_mask(cpu_irq_mask), .tick_irq(tick_irq), .capture_irq(capture_irq),
  .tick_wake(tick_wake), .capture_wake(capture_wake), .dog_reset(dog_reset));

// ### verif/lite_timer_sys_model.sv
// System reset model: stretches a watchdog pulse into a reset
`timescale 1ns/100ps
module lite_timer_sys_model (
  input  wire logic clk,
  input  wire logic por_n,
  input  wire logic dog_reset,
  output      logic rst_n
);
  logic [2:0] hold_q;
  // A one-cycle pulse is too short to be trusted as a reset
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n)
      hold_q <= 3'h0;
    else if (dog_reset)
      hold_q <= 3'h4;
    else if (hold_q != 3'h0)
      hold_q <= hold_q - 3'h1;
  end
  assign rst_n = por_n && (hold_q == 3'h0);
endmodule

// ### verif/lite_timebase_watchdog_capture_tb_top.sv
// Self-checking bench for the lite timer
`timescale 1ns/100ps
`include "lite_timer_regs.svh"
module lite_timebase_watchdog_capture_tb_top;
  localparam logic [11:0] cs_addr = `LT_ADDR_CTRL_STATUS;
  localparam logic [11:0] cap_addr = `LT_ADDR_CAPTURE;
  logic clk = 1'h0, por_n = 1'h0, lvd_rst_n = 1'h0, capture_pin = 1'h0, halt_mode = 1'h0;
  logic wait_mode = 1'h1, cpu_irq_mask = 1'h0, perr, rst_n;
  logic tick_irq, capture_irq, tick_wake, capture_wake, dog_reset;
  logic [7:0] rdata, exp_cap;
  lite_timer_pkg::apb_req_t req = '0;
  lite_timer_pkg::apb_rsp_t rsp;
  int cyc, num_errors, compares, seen;

  always #12.5 clk = ~clk;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cyc <= 0;
    else
      cyc <= cyc + 1;
  end

  lite_timer_sys_model sys (.clk(clk), .por_n(por_n), .dog_reset(dog_reset), .rst_n(rst_n));
  lite_timebase_watchdog_capture dut (
    .clk(clk), .rst_n(rst_n), .lvd_rst_n(lvd_rst_n), .apb_req(req), .apb_rsp(rsp),
    .capture_pin(capture_pin), .hw_dog_opt(1'h0), .halt_reset_opt(1'h0),
    .resume_long_sel(1'h0), .halt_mode(halt_mode), .wait_mode(wait_mode),
    .active_halt_mode(1'h0), .cpu_irq_mask(cpu_irq_mask), .tick_irq(tick_irq),
    .capture_irq(capture_irq), .tick_wake(tick_wake), .capture_wake(capture_wake),
    .dog_reset(dog_reset));

  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready and data are taken at the rising edge; outputs there still hold pre-edge values
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    req <= '{1'h1, 1'h0, w, a, {24'h000000, d}};
    @(posedge clk);
    req.penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'h1 && n < 16);
    rdata = rsp.prdata[7:0];
    perr = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
    if (rsp.pready !== 1'h1) begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    xfer(1'h0, a, 8'h00);
    chk(nm, {24'h000000, e}, {24'h000000, rdata});
  endtask

  // Cycle stamps count from the last reset, as the hidden counter does
  task automatic wait_sig(input logic dog, input int lo, input int hi, input string nm);
    @(negedge clk);
    while ((dog ? dog_reset : tick_irq) !== 1'h1 && cyc <= hi)
      @(negedge clk);
    compares++;
    if (cyc < lo || cyc > hi) begin
      num_errors++;
      $display("ERROR %s expected %0d to %0d seen %0d", nm, lo, hi, cyc);
    end
    if (cyc > hi)
      final_report();
    if (dog)
      repeat (8) @(posedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    por_n <= 1'h1;
    lvd_rst_n <= 1'h1;
    rd(cs_addr, 8'h00, "ctrl reset");
    rd(cap_addr, 8'h00, "capture reset");
    xfer(1'h0, 12'h040, 8'h00);
    chk("unmapped", 32'h1, {31'h0, perr});
    xfer(1'h1, cs_addr, 8'h30);
    wait_sig(1'h0, 15980, 16000, "double tick");
    chk("tick wake", 32'h1, {31'h0, tick_wake});
    rd(cs_addr, 8'h38, "tick flag");
    rd(cs_addr, 8'h30, "tick read clear");
    xfer(1'h1, cs_addr, 8'h18);
    rd(cs_addr, 8'h10, "flag write");
    wait_sig(1'h0, 23975, 23995, "single tick");
    rd(cs_addr, 8'h18, "tick again");
    xfer(1'h1, cs_addr, 8'h80);
    @(negedge clk);
    while (((cyc % 7994) % 32) != 8)
      @(negedge clk);
    exp_cap = 8'((cyc % 7994) / 32);
    @(posedge clk);
    capture_pin <= 1'h1;
    repeat (8) @(negedge clk);
    chk("capture irq", 32'h1, {31'h0, capture_irq});
    chk("capture wake", 32'h1, {31'h0, capture_wake});
    @(posedge clk);
    capture_pin <= 1'h0;
    cpu_irq_mask <= 1'h1;
    repeat (3) @(negedge clk);
    chk("masked irq", 32'h0, {31'h0, capture_irq});
    @(posedge clk);
    cpu_irq_mask <= 1'h0;
    repeat (40) @(negedge clk);
    rd(cap_addr, exp_cap, "capture value");
    rd(cs_addr, 8'h80, "capture clear");
    xfer(1'h1, cs_addr, 8'h02);
    wait_sig(1'h1, cyc, cyc + 6, "late enable");
    xfer(1'h1, cs_addr, 8'h02);
    wait_sig(1'h1, cyc, cyc + 6, "stale status");
    rd(cs_addr, 8'h04, "dog status");
    rd(cs_addr, 8'h00, "status clear");
    xfer(1'h1, cs_addr, 8'h02);
    xfer(1'h1, cs_addr, 8'h06);
    wait_sig(1'h1, cyc, cyc + 6, "forced");
    rd(cs_addr, 8'h04, "forced status");
    rd(cs_addr, 8'h00, "status clear");
    xfer(1'h1, cs_addr, 8'h03);
    wait_sig(1'h1, 31970, 31990, "delayed dog");
    @(posedge clk);
    lvd_rst_n <= 1'h0;
    @(posedge clk);
    lvd_rst_n <= 1'h1;
    rd(cs_addr, 8'h00, "supply clear");
    xfer(1'h1, cs_addr, 8'h03);
    @(posedge clk);
    halt_mode <= 1'h1;
    seen = 0;
    repeat (17000) begin
      @(negedge clk);
      if (dog_reset === 1'h1)
        seen++;
    end
    chk("halt dog", 32'h0, 32'(seen));
    final_report();
  end
endmodule
